//--- common/scc_cfg.svh
// Constants of the socket connection controller: commands, flag bits,
// protocol codes and timing. Included by the design and the testbench.
//
// Notes on behaviour
// - Peer disconnect sets teardown flag, peer_closing.
// - Teardown command ends in shut plus flag.
// - Unanswered TCP packet past retries closes socket.
// - Final TCP expiry sets the timeout flag.
// - Event flags clear by writing one.
// - Masked socket flag sets the global flag; masked global flag raises the interrupt.
// - Connect sends request; may expire on timeouts.
// - Protocol code two plus open gives datagram_open.
// - Eight independent sockets with own registers.
// - Broadcast datagram skips resolution, never expires.
// - Unicast datagram resolves first; expiry drops it.
// - Command register reads zero when done.
// - Protocol code one plus open gives opened.
// - Listening socket answers request, then connects.
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_NSOCK 8
`define SCC_CMD_OPEN 8'h01
`define SCC_CMD_LISTEN 8'h02
`define SCC_CMD_CONNECT 8'h04
`define SCC_CMD_TEARDOWN 8'h08
`define SCC_CMD_CLOSE 8'h10
`define SCC_CMD_SEND 8'h20
`define SCC_CMD_RX_EVENT_FLAG 8'h40
`define SCC_F_CONNECT 0
`define SCC_F_TEARDOWN 1
`define SCC_F_RX 2
`define SCC_F_EXPIRY 3
`define SCC_F_SENDOK 4
`define SCC_PROTO_TCP 4'h1
`define SCC_PROTO_UDP 4'h2
`define SCC_BCAST_IP 32'hffffffff
`define SCC_CLK_NS 10
`define SCC_TICK_NS 100000
`define SCC_TICK_CYC (`SCC_TICK_NS / `SCC_CLK_NS)
`define SCC_FIFO_DEPTH 4
`endif

//--- common/scc_pkg.sv
// Types shared by the socket connection controller.
// Assumes scc_cfg.svh is on the include path.
package scc_pkg;
   // distinct state codes
   // Socket states; the enum order fixes each code.
   typedef enum logic [3:0] {
      state_shut, state_opened, state_waiting_peer, state_handshake_rcvd,
      state_established, state_peer_closing, state_datagram_open,
      state_connecting, state_closing
   } scc_state_t;
   typedef enum logic [2:0] {
      ev_syn, ev_synack, ev_ack, ev_fin, ev_data, ev_arp_reply
   } scc_evt_t;
   typedef enum logic [2:0] {
      pk_syn, pk_synack, pk_ack, pk_fin, pk_data, pk_arp_req
   } scc_pkt_t;
   typedef struct packed {
      scc_state_t state;
      logic [7:0] cmd;
      logic [3:0] proto;
      logic [15:0] port;
      logic [7:0] flags;
      logic bcast;
      logic pend_v;
      scc_pkt_t pend_k;
      logic await;
      logic [15:0] wait_cnt;
      logic [7:0] tries;
   } scc_sock_t;
endpackage : scc_pkg

//--- design/scc_ctrl.sv
// Socket connection controller: eight command-driven sockets and the
// queue of outgoing packet descriptors.
// Assumes the network side reports received packets as one-cycle events
// and drains descriptors with valid/ready.
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_fifo #(
   parameter int W = 8,
   parameter int D = `SCC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int CW = $clog2(D + 1);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [CW-1:0] cnt;
      logic vld;
      logic rdy;
   } scc_fifo_t;
   scc_fifo_t q, d;
   if (D < 2) begin : g_chk
      $error("fifo depth below two");
   end
   // The head always sits in entry zero, so the drain data is a flop.
   always_comb begin
      logic [CW-1:0] c;
      c = q.cnt;
      d = q;
      if (q.vld && out_ready_i) begin
         for (int i = 0; i < D - 1; i++) begin
            d.mem[i] = q.mem[i+1];
         end
         c = CW'(q.cnt - 1'b1);
      end
      if (in_valid_i && q.rdy) begin
         d.mem[c] = in_data_i;
         c = CW'(c + 1'b1);
      end
      d.cnt = c;
      d.vld = (c != '0);
      d.rdy = (c != CW'(D));
   end
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         q <= '0;
         q.rdy <= 1'b1;
      end else begin
         q <= d;
      end
   end
   assign in_ready_o = q.rdy;
   assign out_valid_o = q.vld;
   assign out_data_o = q.mem[0];
endmodule : scc_fifo

module scc_ctrl import scc_pkg::*; #(
   parameter int NSOCK = `SCC_NSOCK,
   parameter int TICK_CYC = `SCC_TICK_CYC
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Command write
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_sock_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [31:0] cmd_dest_ip_i,
   // Socket configuration write
   input wire logic cfg_valid_i,
   input wire logic [2:0] cfg_sock_i,
   input wire logic [3:0] cfg_protocol_select_i,
   input wire logic [15:0] cfg_source_port_i,
   // Flag clearing, masks and retry settings
   input wire logic flag_clr_valid_i,
   input wire logic [2:0] flag_clr_sock_i,
   input wire logic [7:0] flag_clr_bits_i,
   input wire logic [NSOCK-1:0][7:0] socket_event_mask_i,
   input wire logic [NSOCK-1:0] global_event_mask_i,
   input wire logic [NSOCK-1:0] global_clr_i,
   input wire logic [15:0] retry_period_setting_i,
   input wire logic [7:0] retry_limit_setting_i,
   // Network events
   input wire logic ev_valid_i,
   input wire logic [2:0] ev_sock_i,
   input wire scc_evt_t ev_kind_i,
   // Outgoing packet descriptors {socket, kind, source port}
   output logic tx_valid_o,
   output logic [21:0] tx_desc_o,
   input wire logic tx_ready_i,
   // Status
   output scc_state_t [NSOCK-1:0] socket_state_reg_o,
   output logic [NSOCK-1:0][7:0] socket_command_reg_o,
   output logic [NSOCK-1:0][7:0] socket_event_flags_o,
   output logic [NSOCK-1:0] global_event_flags_o,
   output logic irq_o
);
   localparam int TW = $clog2(TICK_CYC + 1);
   typedef struct packed {
      scc_sock_t [NSOCK-1:0] sk;
      logic [2:0] ptr;
      logic [NSOCK-1:0] glb;
      logic irq;
      logic [TW-1:0] tick;
   } scc_top_t;
   scc_top_t q, d;
   logic push;
   logic [21:0] push_w;
   logic fifo_rdy;
   if (NSOCK != 8 || TICK_CYC < 1) begin : g_chk
      $error("socket count must be eight");
   end

   // ---------------------------------------------------------------
   // Socket engines
   // ---------------------------------------------------------------
   // One socket per cycle gets the scanner slot, so at most one
   // descriptor enters the queue per cycle; a full queue stalls it.
   always_comb begin
      scc_sock_t s;
      logic [7:0] fset;
      logic tick;
      s = '0;
      fset = '0;
      d = q;
      push = 1'b0;
      push_w = '0;
      tick = (q.tick == '0);
      d.tick = tick ? TW'(TICK_CYC - 1) : TW'(q.tick - 1'b1);
      d.ptr = 3'(q.ptr + 1'b1);
      d.glb = q.glb & ~global_clr_i;
      for (int i = 0; i < NSOCK; i++) begin
         s = q.sk[i];
         fset = '0;
         if (s.await && tick && s.wait_cnt != '0) begin
            s.wait_cnt = 16'(s.wait_cnt - 1'b1);
         end
         if (q.ptr == 3'(i)) begin
            if (s.cmd == `SCC_CMD_CLOSE) begin
               s.state = state_shut;
               s.pend_v = 1'b0;
               s.await = 1'b0;
               s.cmd = 8'h00;
            end else if (s.await && s.wait_cnt == '0) begin
               if (s.tries >= retry_limit_setting_i) begin
                  fset[`SCC_F_EXPIRY] = 1'b1;
                  s.await = 1'b0;
                  s.cmd = 8'h00;
                  if (s.state != state_datagram_open) begin
                     s.state = state_shut;
                  end
               end else begin
                  s.tries = 8'(s.tries + 1'b1);
                  s.await = 1'b0;
                  s.pend_v = 1'b1;
               end
            end else if (s.pend_v && fifo_rdy) begin
               push = 1'b1;
               push_w = {3'(i), s.pend_k, s.port};
               s.pend_v = 1'b0;
               s.await = (s.pend_k != pk_ack) && !(s.pend_k == pk_data
                         && s.state == state_datagram_open);
               s.wait_cnt = retry_period_setting_i;
               if (s.pend_k == pk_data && s.state == state_datagram_open)
               begin
                  fset[`SCC_F_SENDOK] = 1'b1;
                  s.cmd = 8'h00;
               end
            end else if (s.cmd != 8'h00 && !s.pend_v && !s.await) begin
               s.tries = 8'h00;
               s.cmd = 8'h00;
               // The copy in s is already cleared, so decode the old code.
               case (q.sk[i].cmd)
                  `SCC_CMD_OPEN: begin
                     if (s.proto == `SCC_PROTO_TCP) begin
                        s.state = state_opened;
                     end else if (s.proto == `SCC_PROTO_UDP) begin
                        s.state = state_datagram_open;
                     end else begin
                        s.state = state_shut;
                     end
                  end
                  `SCC_CMD_LISTEN: begin
                     if (s.state == state_opened) begin
                        s.state = state_waiting_peer;
                     end
                  end
                  `SCC_CMD_CONNECT: begin
                     if (s.state == state_opened) begin
                        s.state = state_connecting;
                        s.pend_v = 1'b1;
                        s.pend_k = pk_arp_req;
                     end
                  end
                  `SCC_CMD_TEARDOWN: begin
                     if (s.state == state_established ||
                         s.state == state_peer_closing) begin
                        s.state = state_closing;
                        s.pend_v = 1'b1;
                        s.pend_k = pk_fin;
                     end
                  end
                  `SCC_CMD_SEND: begin
                     s.pend_v = (s.state == state_established) ||
                                (s.state == state_datagram_open);
                     s.pend_k = (s.state == state_datagram_open &&
                                 !s.bcast) ? pk_arp_req : pk_data;
                     s.cmd = s.pend_v ? `SCC_CMD_SEND : 8'h00;
                  end
                  default: begin
                  end
               endcase
            end
         end
         if (ev_valid_i && ev_sock_i == 3'(i)) begin
            case (ev_kind_i)
               ev_syn: begin
                  if (s.state == state_waiting_peer) begin
                     s.state = state_handshake_rcvd;
                     s.pend_v = 1'b1;
                     s.pend_k = pk_synack;
                     s.tries = 8'h00;
                  end
               end
               ev_synack: begin
                  if (s.state == state_connecting) begin
                     s.state = state_established;
                     fset[`SCC_F_CONNECT] = 1'b1;
                     s.await = 1'b0;
                     s.pend_v = 1'b1;
                     s.pend_k = pk_ack;
                  end
               end
               ev_ack: begin
                  s.await = 1'b0;
                  if (s.state == state_handshake_rcvd) begin
                     s.state = state_established;
                     fset[`SCC_F_CONNECT] = 1'b1;
                  end else if (s.state == state_closing) begin
                     s.state = state_shut;
                     fset[`SCC_F_TEARDOWN] = 1'b1;
                  end else if (s.cmd == `SCC_CMD_SEND) begin
                     fset[`SCC_F_SENDOK] = 1'b1;
                     s.cmd = 8'h00;
                  end
               end
               ev_fin: begin
                  if (s.state == state_established) begin
                     s.state = state_peer_closing;
                     fset[`SCC_F_TEARDOWN] = 1'b1;
                  end else if (s.state == state_closing) begin
                     s.state = state_shut;
                     s.await = 1'b0;
                     fset[`SCC_F_TEARDOWN] = 1'b1;
                  end
               end
               ev_data: begin
                  if (s.state == state_established ||
                      s.state == state_datagram_open) begin
                     fset[`SCC_F_RX] = 1'b1;
                  end
               end
               ev_arp_reply: begin
                  // datagram goes out only once resolved
                  if (s.await && s.pend_k == pk_arp_req) begin
                     s.await = 1'b0;
                     s.pend_v = 1'b1;
                     s.tries = 8'h00;
                     s.pend_k = (s.state == state_connecting) ?
                                pk_syn : pk_data;
                  end
               end
               default: begin
               end
            endcase
         end
         if (cmd_valid_i && cmd_sock_i == 3'(i)) begin
            s.cmd = cmd_code_i;
            s.bcast = (cmd_dest_ip_i == `SCC_BCAST_IP);
         end
         if (cfg_valid_i && cfg_sock_i == 3'(i)) begin
            s.proto = cfg_protocol_select_i;
            s.port = cfg_source_port_i;
         end
         // write one clears, a new event wins
         if (flag_clr_valid_i && flag_clr_sock_i == 3'(i)) begin
            s.flags = s.flags & ~flag_clr_bits_i;
         end
         s.flags = s.flags | fset;
         // masked flag reaches the global flag
         if ((fset & socket_event_mask_i[i]) != 8'h00) begin
            d.glb[i] = 1'b1;
         end
         d.sk[i] = s;
      end
      d.irq = |(d.glb & global_event_mask_i);
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   scc_fifo #(.W(22), .D(`SCC_FIFO_DEPTH)) u_txq (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .in_valid_i(push),
      .in_data_i(push_w),
      .in_ready_o(fifo_rdy),
      .out_valid_o(tx_valid_o),
      .out_data_o(tx_desc_o),
      .out_ready_i(tx_ready_i)
   );

   for (genvar g = 0; g < NSOCK; g++) begin : g_out
      assign socket_state_reg_o[g] = q.sk[g].state;
      assign socket_command_reg_o[g] = q.sk[g].cmd;
      assign socket_event_flags_o[g] = q.sk[g].flags;
   end
   assign global_event_flags_o = q.glb;
   assign irq_o = q.irq;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   scc_sock_t cur, evs;
   logic exec, expire;
   assign cur = q.sk[q.ptr];
   assign evs = q.sk[ev_sock_i];
   assign exec = cur.cmd != 8'h00 && cur.cmd != `SCC_CMD_CLOSE &&
                 !cur.pend_v && !cur.await && !ev_valid_i;
   assign expire = cur.await && cur.wait_cnt == '0 &&
                   cur.tries >= retry_limit_setting_i && !ev_valid_i &&
                   cur.state != state_datagram_open;
   peer_close_a: assert property (
      ev_valid_i && ev_kind_i == ev_fin && evs.state == state_established
      |=> q.sk[$past(ev_sock_i)].state == state_peer_closing &&
          q.sk[$past(ev_sock_i)].flags[`SCC_F_TEARDOWN])
      else $error("peer disconnect not reported");
   teardown_end_a: assert property (
      ev_valid_i && ev_kind_i == ev_ack && evs.state == state_closing
      |=> q.sk[$past(ev_sock_i)].state == state_shut &&
          q.sk[$past(ev_sock_i)].flags[`SCC_F_TEARDOWN])
      else $error("teardown did not close");
   tcp_expiry_a: assert property (
      expire |=> q.sk[$past(q.ptr)].state == state_shut)
      else $error("expired socket not shut");
   expiry_flag_a: assert property (
      expire |=> q.sk[$past(q.ptr)].flags[`SCC_F_EXPIRY])
      else $error("expiry flag missing");
   flag_clear_a: assert property (
      flag_clr_valid_i && flag_clr_bits_i == 8'hff && !ev_valid_i &&
      q.ptr != flag_clr_sock_i
      |=> q.sk[$past(flag_clr_sock_i)].flags == 8'h00)
      else $error("flags not cleared");
   irq_gate_a: assert property (
      ##1 irq_o == |(q.glb & $past(global_event_mask_i)))
      else $error("interrupt does not follow flags");
   connect_a: assert property (
      exec && cur.cmd == `SCC_CMD_CONNECT && cur.state == state_opened
      |=> q.sk[$past(q.ptr)].state == state_connecting
          ##[1:16] tx_valid_o && tx_desc_o[18:16] == pk_arp_req)
      else $error("connect sent no request");
   udp_open_a: assert property (
      exec && cur.cmd == `SCC_CMD_OPEN && cur.proto == `SCC_PROTO_UDP
      |=> q.sk[$past(q.ptr)].state == state_datagram_open)
      else $error("datagram open failed");
   bcast_a: assert property (
      push && push_w[18:16] == pk_arp_req
      |-> !q.sk[push_w[21:19]].bcast)
      else $error("broadcast resolved");
   cmd_zero_a: assert property (
      exec && cur.cmd == `SCC_CMD_OPEN && !(cmd_valid_i &&
      cmd_sock_i == q.ptr) |=> q.sk[$past(q.ptr)].cmd == 8'h00)
      else $error("command not cleared");
   tcp_open_a: assert property (
      exec && cur.cmd == `SCC_CMD_OPEN && cur.proto == `SCC_PROTO_TCP
      |=> q.sk[$past(q.ptr)].state == state_opened)
      else $error("tcp open failed");
   syn_rcvd_a: assert property (
      ev_valid_i && ev_kind_i == ev_syn && evs.state == state_waiting_peer
      |=> q.sk[$past(ev_sock_i)].state == state_handshake_rcvd)
      else $error("request not answered");
   cover property (tx_valid_o && tx_desc_o[18:16] == pk_synack);
   cover property (expire);
   cover property (irq_o);
endmodule : scc_ctrl

//--- tb/scc_remote_model.sv
// Remote host model: drains packet descriptors and answers them.
// Assumes the controller samples events on the rising clock edge.
`timescale 1ns/1ps
module scc_remote_model import scc_pkg::*; (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Descriptor stream
   input wire logic tx_valid_i,
   input wire logic [21:0] tx_desc_i,
   output logic tx_ready_o,
   // Events to the controller
   output logic ev_valid_o,
   output logic [2:0] ev_sock_o,
   output scc_evt_t ev_kind_o,
   // Bench controls
   input wire logic silent_i,
   input wire logic slow_i,
   input wire logic stall_i,
   input wire logic inj_valid_i,
   input wire logic [2:0] inj_sock_i,
   input wire scc_evt_t inj_kind_i,
   // Observation
   output logic [7:0] seen_o,
   output scc_pkt_t last_o
);
   scc_pkt_t k;
   logic rep_v;
   logic fired;
   logic [2:0] rep_s;
   scc_evt_t rep_k;
   int rep_w;

   initial begin
      tx_ready_o = 1'b0;
      ev_valid_o = 1'b0;
      ev_sock_o = 3'h0;
      ev_kind_o = ev_syn;
      fired = 1'b0;
   end

   assign k = scc_pkt_t'(tx_desc_i[18:16]);

   // answer each request
   // Even the slow answer lands before the first retry slot, so that no
   // retransmission restarts the delay and starves the handshake.
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         seen_o <= 8'h00;
         rep_v <= 1'b0;
      end else if (tx_valid_i && tx_ready_o) begin
         seen_o <= seen_o + 8'h01;
         last_o <= k;
         rep_s <= tx_desc_i[21:19];
         rep_w <= slow_i ? 4 : 1;
         rep_v <= !silent_i && k != pk_ack && k != pk_data;
         rep_k <= (k == pk_syn) ? ev_synack :
            (k == pk_arp_req) ? ev_arp_reply : ev_ack;
      end else if (fired) begin
         rep_v <= 1'b0;
      end else if (rep_w > 0) begin
         rep_w <= rep_w - 1;
      end
   end

   // Idle event lines toggle so that a stale value is never mistaken.
   always @(negedge core_clk_i) begin
      tx_ready_o <= !stall_i;
      ev_valid_o <= 1'b0;
      fired <= 1'b0;
      ev_sock_o <= ~ev_sock_o;
      ev_kind_o <= scc_evt_t'(~ev_kind_o);
      if (inj_valid_i) begin
         ev_valid_o <= 1'b1;
         ev_sock_o <= inj_sock_i;
         ev_kind_o <= inj_kind_i;
      end else if (rep_v && rep_w == 0) begin
         ev_valid_o <= 1'b1;
         ev_sock_o <= rep_s;
         ev_kind_o <= rep_k;
         fired <= 1'b1;
      end
   end
endmodule : scc_remote_model

//--- tb/testbench.sv
// Self-checking bench of the socket controller and a remote host model.
// Assumes the package, design and remote model are compiled first.
`timescale 1ns/1ps
`include "scc_cfg.svh"
module testbench import scc_pkg::*; ();
   logic core_clk;
   logic rst = 1'b1;
   logic cmd_v = 1'b0;
   logic [2:0] cmd_s = 3'h0;
   logic [7:0] cmd_c = 8'h00;
   logic [31:0] cmd_ip = 32'h0;
   logic cfg_v = 1'b0;
   logic [2:0] cfg_s = 3'h0;
   logic [3:0] cfg_p = 4'h0;
   logic clr_v = 1'b0;
   logic [2:0] clr_s = 3'h0;
   logic [7:0] clr_b = 8'h00;
   logic [7:0] gmask = 8'h00;
   logic [7:0] gclr = 8'h00;
   logic silent = 1'b0;
   logic slow = 1'b0;
   logic stall = 1'b0;
   logic inj_v = 1'b0;
   logic [2:0] inj_s = 3'h0;
   scc_evt_t inj_k = ev_syn;
   logic ev_v, tx_v, tx_r, irq;
   logic [2:0] ev_s;
   scc_evt_t ev_k;
   logic [21:0] tx_d;
   scc_state_t [7:0] st;
   logic [7:0][7:0] cr;
   logic [7:0][7:0] fl;
   logic [7:0] gf, seen, base;
   scc_pkt_t last;
   int n;
   int err_total = 0;
   int cmp_count = 0;

   scc_ctrl #(.NSOCK(8), .TICK_CYC(2)) scc_ctrl_inst (
      .core_clk_i(core_clk), .reset_i(rst),
      .cmd_valid_i(cmd_v), .cmd_sock_i(cmd_s), .cmd_code_i(cmd_c),
      .cmd_dest_ip_i(cmd_ip), .cfg_valid_i(cfg_v), .cfg_sock_i(cfg_s),
      .cfg_protocol_select_i(cfg_p), .cfg_source_port_i({13'h0400, cfg_s}),
      .flag_clr_valid_i(clr_v), .flag_clr_sock_i(clr_s),
      .flag_clr_bits_i(clr_b), .socket_event_mask_i(64'hffffffffffffffff),
      .global_event_mask_i(gmask), .global_clr_i(gclr),
      .retry_period_setting_i(16'h0002), .retry_limit_setting_i(8'h02),
      .ev_valid_i(ev_v), .ev_sock_i(ev_s), .ev_kind_i(ev_k),
      .tx_valid_o(tx_v), .tx_desc_o(tx_d), .tx_ready_i(tx_r),
      .socket_state_reg_o(st), .socket_command_reg_o(cr),
      .socket_event_flags_o(fl), .global_event_flags_o(gf), .irq_o(irq));

   scc_remote_model scc_remote_model_inst (
      .core_clk_i(core_clk), .reset_i(rst), .tx_valid_i(tx_v),
      .tx_desc_i(tx_d), .tx_ready_o(tx_r), .ev_valid_o(ev_v),
      .ev_sock_o(ev_s), .ev_kind_o(ev_k), .silent_i(silent),
      .slow_i(slow), .stall_i(stall), .inj_valid_i(inj_v),
      .inj_sock_i(inj_s), .inj_kind_i(inj_k), .seen_o(seen),
      .last_o(last));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ----
   // Tasks
   // ----
   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp);
      cmp_count++;
      if (seen_v !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen_v, exp);
      end
   endtask : check

   task automatic finish_test;
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // Non-blocking drives keep the model, which also acts at the falling
   // edge, from racing the bench.
   task automatic cmd(input int s, input logic [7:0] c, input logic [31:0] ip);
      @(negedge core_clk);
      cmd_v <= 1'b1;
      cmd_s <= 3'(s);
      cmd_c <= c;
      cmd_ip <= ip;
      @(negedge core_clk);
      cmd_v <= 1'b0;
      @(negedge core_clk);
   endtask : cmd

   task automatic cfg(input int s, input logic [3:0] p);
      @(negedge core_clk);
      cfg_v <= 1'b1;
      cfg_s <= 3'(s);
      cfg_p <= p;
      @(negedge core_clk);
      cfg_v <= 1'b0;
   endtask : cfg

   task automatic clr(input int s, input logic [7:0] b);
      @(negedge core_clk);
      clr_v <= 1'b1;
      clr_s <= 3'(s);
      clr_b <= b;
      gclr <= 8'h01 << s;
      @(negedge core_clk);
      clr_v <= 1'b0;
      gclr <= 8'h00;
   endtask : clr

   task automatic inj(input int s, input scc_evt_t k);
      @(negedge core_clk);
      inj_v <= 1'b1;
      inj_s <= 3'(s);
      inj_k <= k;
      @(negedge core_clk);
      inj_v <= 1'b0;
   endtask : inj

   task automatic settle(input int s, input scc_state_t q, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(negedge core_clk);
         if (st[s] === q && cr[s] === 8'h00) return;
      end
      err_total++;
      $display("[FAIL] %0t socket %0d stuck", $time, s);
      finish_test();
   endtask : settle

   // ----
   // Scenarios
   // ----
   initial begin
      repeat (8) @(negedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      for (int s = 0; s < 8; s++) begin
         check(st[s], state_shut);
         check(cr[s], 8'h00);
         check(fl[s], 8'h00);
      end
      // passive open against a slow peer.
      cfg(0, `SCC_PROTO_TCP);
      cmd(0, `SCC_CMD_OPEN, 32'h0);
      settle(0, state_opened, 20);
      check(st[0], state_opened);
      cmd(0, `SCC_CMD_LISTEN, 32'h0);
      settle(0, state_waiting_peer, 20);
      slow <= 1'b1;
      inj(0, ev_syn);
      settle(0, state_handshake_rcvd, 10);
      check(st[0], state_handshake_rcvd);
      settle(0, state_established, 100);
      slow <= 1'b0;
      check(last, pk_synack);
      check(fl[0][`SCC_F_CONNECT], 1'b1);
      check(gf[0], 1'b1);
      check(irq, 1'b0);
      gmask <= 8'h01;
      repeat (2) @(negedge core_clk);
      check(irq, 1'b1);
      clr(0, 8'hff);
      repeat (2) @(negedge core_clk);
      check(fl[0], 8'h00);
      check(irq, 1'b0);
      inj(0, ev_fin);
      settle(0, state_peer_closing, 10);
      check(fl[0][`SCC_F_TEARDOWN], 1'b1);
      clr(0, 8'hff);
      cmd(0, `SCC_CMD_TEARDOWN, 32'h0);
      settle(0, state_shut, 100);
      check(last, pk_fin);
      check(fl[0][`SCC_F_TEARDOWN], 1'b1);
      // client connects, then closes at will.
      cfg(2, `SCC_PROTO_TCP);
      cmd(2, `SCC_CMD_OPEN, 32'h0);
      settle(2, state_opened, 20);
      cmd(2, `SCC_CMD_CONNECT, 32'h0a000002);
      settle(2, state_established, 200);
      check(fl[2][`SCC_F_CONNECT], 1'b1);
      clr(2, 8'hff);
      cmd(2, `SCC_CMD_CLOSE, 32'h0);
      settle(2, state_shut, 20);
      check(fl[2], 8'h00);
      silent <= 1'b1;
      cfg(1, `SCC_PROTO_TCP);
      cmd(1, `SCC_CMD_OPEN, 32'h0);
      settle(1, state_opened, 20);
      base = seen;
      cmd(1, `SCC_CMD_CONNECT, 32'h0a000003);
      settle(1, state_shut, 300);
      check(fl[1][`SCC_F_EXPIRY], 1'b1);
      check(seen - base, 8'h03);
      check(st[7], state_shut);
      for (int s = 3; s < 8; s++) begin
         cfg(s, `SCC_PROTO_UDP);
         cmd(s, `SCC_CMD_OPEN, 32'h0);
         settle(s, state_datagram_open, 20);
         check(st[s], state_datagram_open);
      end
      // unicast datagram with no resolution answer.
      base = seen;
      cmd(3, `SCC_CMD_SEND, 32'h0a000004);
      settle(3, state_datagram_open, 300);
      check(fl[3][`SCC_F_EXPIRY], 1'b1);
      check(last, pk_arp_req);
      check(seen - base, 8'h03);
      clr(3, 8'hff);
      // two datagrams merge into one receive flag.
      inj(3, ev_data);
      inj(3, ev_data);
      settle(3, state_datagram_open, 5);
      check(fl[3][`SCC_F_RX], 1'b1);
      // five broadcasts into a stalled queue of four.
      stall <= 1'b1;
      base = seen;
      for (int s = 3; s < 8; s++) begin
         cmd(s, `SCC_CMD_SEND, `SCC_BCAST_IP);
      end
      repeat (20) @(negedge core_clk);
      n = 0;
      for (int s = 3; s < 8; s++) begin
         n += int'(cr[s] !== 8'h00);
      end
      check(n, 1);
      check(tx_v, 1'b1);
      stall <= 1'b0;
      repeat (20) @(negedge core_clk);
      check(seen - base, 8'h05);
      check(last, pk_data);
      check(tx_v, 1'b0);
      for (int s = 3; s < 8; s++) begin
         check(fl[s][`SCC_F_EXPIRY], 1'b0);
      end
      finish_test();
   end
endmodule : testbench
